// ---- sam_pkg.sv ----
// constants, opcodes and state type for the shader alu misc-op unit
package sam_pkg;
    localparam logic [7:0] OP_SPLIT_DOUBLE = 8'hc4;
    localparam logic [7:0] OP_BARRIER = 8'h54;
    localparam logic [7:0] OP_SEQ_OPEN = 8'h55;
    localparam logic [7:0] OP_SEQ_CLOSE = 8'h56;
    localparam logic [7:0] OP_INT_TO_SINGLE = 8'h9b;
    localparam logic [7:0] OP_LOAD_V0 = 8'he0;
    localparam logic [7:0] OP_LOAD_D1 = 8'he1;
    localparam logic [7:0] OP_LOAD_D2 = 8'he2;
    localparam logic [7:0] OP_INTERP_FIRST_CHANNEL = 8'hd8;
    localparam logic [7:0] OP_INTERP_FIRST_TWO_CHANNELS = 8'hd6;
    localparam int THREADS = 8;
    localparam int THR_W = 3;
    localparam int PARAM_COUNT = 33;
    localparam logic [5:0] PARAM_MAX = 6'h20;
    localparam logic [10:0] DBL_EXP_ONES = 11'h7ff;
    localparam logic [10:0] FRAC_BIASED_EXP = 11'h3fe;
    localparam logic [31:0] DBL_BIAS = 32'h000003ff;
    localparam logic [31:0] SPLIT_EXP_SPECIAL = 32'h0fffffff;
    localparam logic [63:0] QUIET_DOUBLE_NAN = 64'hfff8000000000000;
    localparam logic [3:0] SPLIT_SLOTS = 4'hf;
    localparam logic [10:0] SGL_BIAS = 11'h07f;
    localparam logic [7:0] I2F_EXP_BASE = 8'h7f;
    localparam logic signed [11:0] EXT_FRAC = 12'sh02e;
    localparam logic signed [11:0] SGL_EXP_MAX = 12'sh0ff;
    typedef enum logic [2:0] {
        SAM_SEQ_IDLE = 3'b001,
        SAM_SEQ_GATHER = 3'b010,
        SAM_SEQ_RUN = 3'b100
    } sam_seq_t;
endpackage : sam_pkg

// ---- sam_alu_misc.sv ----
// shader alu misc-op unit: split double, int to single, barriers, param loads, interp
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// RL1: split double into exponent and fraction
// RL2: inf or NaN gives all-ones exponent; code gives SPLIT_EXP_SPECIAL 0x0fffffff instead
// RL3: inf gives quiet NaN, NaN passes
// RL4: zero or denormal gives signed zero
// RL5: normal: fraction exponent 0x3fe, exp-1022
// RL6: split double occupies slots zero to three
// RL7: modifiers apply only from slot zero
// RL8: barrier releases group when all arrived
// RL9: no barrier inside dynamic flow control
// RL10: ordered open: barrier, then one thread
// RL11: close passes section to next thread
// RL12: closer continues; every opener must close
// RL13: signed integer to single precision
// RL14: load vertex 0 parameter, index 0-32
// RL15: load vertex 1 minus vertex 0
// RL16: load vertex 2 minus vertex 0
// RL17: x interp: multiply-add then dot add
// RL18: multiply-add unrounded into dot add
// RL19: xy interp in four channels, y routed
// RL20: trackers return idle after release
// RL21: y result uses y components only
module sam_alu_misc
    import sam_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic issueValid,
    input wire logic [7:0] opSelect,
    input wire logic [THR_W-1:0] issueThread,
    input wire logic [3:0] issueSlots,
    input wire logic [3:0] srcNeg,
    input wire logic [3:0] srcAbs,
    input wire logic [63:0] src0,
    input wire logic [THREADS-1:0] groupMask,
    input wire logic [31:0] parV0X,
    input wire logic [31:0] parV0Y,
    input wire logic [31:0] parD1X,
    input wire logic [31:0] parD1Y,
    input wire logic [31:0] parD2X,
    input wire logic [31:0] parD2Y,
    input wire logic [31:0] baryI,
    input wire logic [31:0] baryJ,
    input wire logic ldsWrEn,
    input wire logic [1:0] ldsWrVertex,
    input wire logic [5:0] ldsWrParam,
    input wire logic [127:0] ldsWrData,
    output var logic resValid,
    output var logic [31:0] resX,
    output var logic [31:0] resY,
    output var logic [31:0] resZ,
    output var logic [31:0] resW,
    output var logic issueErr,
    output var logic [THREADS-1:0] threadRelease,
    output var logic [THREADS-1:0] seqGrant
);
    // term layout: {sign, exp[10:0] biased, mantissa[47:0] with 46 fraction bits}
    function automatic logic [59:0] fterm(input logic [31:0] f, input logic neg);
        return {f[31] ^ neg, 3'b000, f[30:23], (f[30:23] == 8'h00) ? 48'h0 : {2'b01, f[22:0], 23'h0}};
    endfunction : fterm

    function automatic logic [59:0] pterm(input logic [31:0] a, input logic [31:0] b);
        logic [47:0] p;
        logic [10:0] e;
        p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
        e = {3'b000, a[30:23]} + {3'b000, b[30:23]} - SGL_BIAS;
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00) p = 48'h0;
        return {a[31] ^ b[31], e, p};
    endfunction : pterm

    // one normalisation for the whole sum, truncating; no intermediate rounding
    function automatic logic [31:0] fsum3(input logic [2:0][59:0] t);
        logic signed [11:0] emax;
        logic signed [11:0] ek;
        logic signed [11:0] d;
        logic signed [51:0] acc;
        logic [51:0] mag;
        logic [51:0] nrm;
        logic [47:0] sh;
        logic [5:0] lead;
        logic signed [11:0] re;
        emax = 12'sh800;
        acc = '0;
        lead = '0;
        for (int k = 0; k < 3; k++) begin
            ek = $signed({t[k][58], t[k][58:48]});
            if (t[k][47:0] != 48'h0 && ek > emax) emax = ek;
        end
        for (int k = 0; k < 3; k++) begin
            d = emax - $signed({t[k][58], t[k][58:48]});
            sh = (d > 12'sd47) ? 48'h0 : t[k][47:0] >> d[5:0];
            acc = t[k][59] ? acc - $signed({4'b0000, sh}) : acc + $signed({4'b0000, sh});
        end
        mag = acc[51] ? 52'(-acc) : acc;
        for (int b = 0; b < 52; b++) begin
            if (mag[b]) lead = 6'(b);
        end
        re = emax + $signed({6'b000000, lead}) - EXT_FRAC;
        nrm = mag << (6'd51 - lead);
        if (mag == 52'h0 || re <= 12'sd0) return 32'h0;
        if (re >= SGL_EXP_MAX) return {acc[51], 8'hff, 23'h0};
        return {acc[51], re[7:0], nrm[50:28]};
    endfunction : fsum3

    // round to nearest even
    function automatic logic [31:0] i2f(input logic [31:0] v);
        logic [31:0] mag;
        logic [31:0] nrm;
        logic [4:0] lead;
        logic [30:0] r;
        mag = v[31] ? 32'(-v) : v;
        lead = '0;
        for (int b = 0; b < 32; b++) begin
            if (mag[b]) lead = 5'(b);
        end
        nrm = mag << (5'd31 - lead);
        r = {I2F_EXP_BASE + {3'b000, lead}, nrm[30:8]} + 31'(nrm[7] & ((|nrm[6:0]) | nrm[8]));
        return (mag == 32'h0) ? 32'h0 : {v[31], r};
    endfunction : i2f

    logic [63:0] splitLo;
    logic [63:0] splitHi;
    logic splitSign;
    logic [31:0] splitExp;
    logic [127:0] ldsMem [0:3*PARAM_COUNT-1];
    logic [5:0] paramIdx;
    logic paramOk;
    logic [127:0] rowV0;
    logic [127:0] rowV1;
    logic [127:0] rowV2;
    logic [31:0] delta1 [4];
    logic [31:0] delta2 [4];
    logic [31:0] interpX;
    logic [31:0] interpY;
    logic [31:0] xNext;
    logic [31:0] yNext;
    logic [31:0] zNext;
    logic [31:0] wNext;
    logic validNext;
    logic errNext;
    logic [THREADS-1:0] thrBit;
    logic [THREADS-1:0] barArr_reg;
    logic [THREADS-1:0] barArr_next;
    logic [THREADS-1:0] seqArr_reg;
    logic [THREADS-1:0] seqArr_next;
    logic [THREADS-1:0] grantNext;
    logic [THREADS-1:0] rem;
    sam_seq_t seqState_reg;
    sam_seq_t seqState_next;

    always_comb begin
        splitSign = (src0[63] & ~srcAbs[0]) ^ srcNeg[0]; // RL7
        splitExp = 32'h0;
        splitHi = {splitSign, 63'h0}; // RL4
        if (src0[62:52] == DBL_EXP_ONES) begin
            splitExp = SPLIT_EXP_SPECIAL; // RL2
            splitHi = (src0[51:0] == 52'h0) ? QUIET_DOUBLE_NAN : {splitSign, src0[62:0]}; // RL3
        end else if (src0[62:52] != 11'h000) begin
            splitHi = {splitSign, FRAC_BIASED_EXP, src0[51:0]}; // RL5
            splitExp = {21'h0, src0[62:52]} - DBL_BIAS + 32'h1; // RL5
        end
        splitLo = {{32{splitExp[31]}}, splitExp}; // RL1
    end

    always_ff @(posedge mclk) begin
        if (ldsWrEn && ldsWrVertex != 2'b11 && ldsWrParam <= PARAM_MAX) begin
            ldsMem[7'(ldsWrVertex) * 7'(PARAM_COUNT) + 7'(ldsWrParam)] <= ldsWrData;
        end
    end

    assign paramOk = src0[5:0] <= PARAM_MAX; // RL14
    assign paramIdx = paramOk ? src0[5:0] : 6'h00;
    assign rowV0 = ldsMem[7'(paramIdx)];
    assign rowV1 = ldsMem[7'(PARAM_COUNT) + 7'(paramIdx)];
    assign rowV2 = ldsMem[7'(2 * PARAM_COUNT) + 7'(paramIdx)];

    for (genvar c = 0; c < 4; c++) begin : g_delta
        assign delta1[c] = fsum3({fterm(rowV1[32*c+:32], 1'b0), fterm(rowV0[32*c+:32], 1'b1), 60'h0}); // RL15
        assign delta2[c] = fsum3({fterm(rowV2[32*c+:32], 1'b0), fterm(rowV0[32*c+:32], 1'b1), 60'h0}); // RL16
    end

    // multiply-add of v0 + d1*i joined in the dot sum with d2*j
    assign interpX = fsum3({fterm(parV0X, 1'b0), pterm(parD1X, baryI), pterm(parD2X, baryJ)}); // RL17 RL18
    assign interpY = fsum3({fterm(parV0Y, 1'b0), pterm(parD1Y, baryI), pterm(parD2Y, baryJ)}); // RL21

    always_comb begin
        xNext = 32'h0;
        yNext = 32'h0;
        zNext = 32'h0;
        wNext = 32'h0;
        validNext = 1'b0;
        errNext = 1'b0;
        if (issueValid) begin
            case (opSelect)
                OP_SPLIT_DOUBLE: begin
                    if (issueSlots == SPLIT_SLOTS) begin // RL6
                        {yNext, xNext} = splitLo; // RL1
                        {wNext, zNext} = splitHi; // RL1
                        validNext = 1'b1;
                    end else begin
                        errNext = 1'b1; // RL6
                    end
                end
                OP_INT_TO_SINGLE: begin
                    xNext = i2f(src0[31:0]); // RL13
                    validNext = 1'b1;
                end
                OP_LOAD_V0, OP_LOAD_D1, OP_LOAD_D2: begin
                    validNext = paramOk;
                    errNext = ~paramOk;
                    if (!paramOk) begin
                        errNext = 1'b1; // RL14
                    end else if (opSelect == OP_LOAD_V0) begin
                        {wNext, zNext, yNext, xNext} = rowV0; // RL14
                    end else if (opSelect == OP_LOAD_D1) begin
                        {wNext, zNext, yNext, xNext} = {delta1[3], delta1[2], delta1[1], delta1[0]};
                    end else begin
                        {wNext, zNext, yNext, xNext} = {delta2[3], delta2[2], delta2[1], delta2[0]};
                    end
                end
                OP_INTERP_FIRST_CHANNEL: begin
                    xNext = interpX; // RL17
                    validNext = 1'b1;
                end
                OP_INTERP_FIRST_TWO_CHANNELS: begin
                    xNext = interpX;
                    yNext = interpY; // RL19
                    validNext = 1'b1;
                end
                default: begin
                    validNext = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            resValid <= 1'b0;
            issueErr <= 1'b0;
            resX <= 32'h0;
            resY <= 32'h0;
            resZ <= 32'h0;
            resW <= 32'h0;
        end else begin
            resValid <= validNext;
            issueErr <= errNext;
            resX <= xNext;
            resY <= yNext;
            resZ <= zNext;
            resW <= wNext;
        end
    end

    assign thrBit = THREADS'(8'h01) << issueThread;

    // arrivals are counted only for threads of the group; callers keep it out of dynamic flow
    always_comb begin
        barArr_next = barArr_reg;
        if (issueValid && opSelect == OP_BARRIER) barArr_next = barArr_reg | (thrBit & groupMask);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            barArr_reg <= '0;
            threadRelease <= '0;
        end else if (groupMask != '0 && (barArr_next & groupMask) == groupMask) begin
            threadRelease <= groupMask; // RL8
            barArr_reg <= '0; // RL20
        end else begin
            threadRelease <= '0;
            barArr_reg <= barArr_next;
        end
    end

    always_comb begin
        seqState_next = seqState_reg;
        seqArr_next = seqArr_reg;
        grantNext = seqGrant;
        rem = groupMask & ~(seqGrant | (seqGrant - THREADS'(8'h01)));
        case (seqState_reg)
            SAM_SEQ_IDLE, SAM_SEQ_GATHER: begin
                if (issueValid && opSelect == OP_SEQ_OPEN) seqArr_next = seqArr_reg | (thrBit & groupMask);
                if (groupMask != '0 && (seqArr_next & groupMask) == groupMask) begin
                    seqState_next = SAM_SEQ_RUN;
                    seqArr_next = '0;
                    grantNext = groupMask & (~groupMask + THREADS'(8'h01)); // RL10
                end else begin
                    seqState_next = (seqArr_next != '0) ? SAM_SEQ_GATHER : SAM_SEQ_IDLE;
                end
            end
            SAM_SEQ_RUN: begin
                if (issueValid && opSelect == OP_SEQ_CLOSE && (seqGrant & thrBit) != '0) begin
                    grantNext = rem & (~rem + THREADS'(8'h01)); // RL11 RL12
                    if (rem == '0) seqState_next = SAM_SEQ_IDLE; // RL20
                end
            end
            default: begin
                seqState_next = SAM_SEQ_IDLE;
                seqArr_next = '0;
                grantNext = '0;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            seqState_reg <= SAM_SEQ_IDLE;
            seqArr_reg <= '0;
            seqGrant <= '0;
        end else begin
            seqState_reg <= seqState_next;
            seqArr_reg <= seqArr_next;
            seqGrant <= grantNext;
        end
    end

    property p_split_special;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots == SPLIT_SLOTS
            && src0[62:52] == DBL_EXP_ONES |=> resValid && resX == SPLIT_EXP_SPECIAL;
    endproperty
    a_split_special: assert property (p_split_special) else $error("special exponent wrong"); // RL2
    property p_split_inf;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots == SPLIT_SLOTS
            && src0[62:0] == {DBL_EXP_ONES, 52'h0} |=> {resW, resZ} == QUIET_DOUBLE_NAN;
    endproperty
    a_split_inf: assert property (p_split_inf) else $error("inf fraction not quiet nan"); // RL3
    property p_split_zero;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots == SPLIT_SLOTS
            && src0[62:52] == 11'h000 |=> resX == 32'h0 && resZ == 32'h0 && resW[30:0] == 31'h0;
    endproperty
    a_split_zero: assert property (p_split_zero) else $error("zero split wrong"); // RL4
    property p_split_normal;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots == SPLIT_SLOTS
            && src0[62:52] != 11'h000 && src0[62:52] != DBL_EXP_ONES
            |=> resW[30:20] == FRAC_BIASED_EXP && resX == {21'h0, $past(src0[62:52])} - 32'h3fe;
    endproperty
    a_split_normal: assert property (p_split_normal) else $error("normal split wrong"); // RL5
    property p_split_slots;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots != SPLIT_SLOTS |=> issueErr && !resValid;
    endproperty
    a_split_slots: assert property (p_split_slots) else $error("bad slot split accepted"); // RL6
    property p_split_sign;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_SPLIT_DOUBLE && issueSlots == SPLIT_SLOTS && !srcAbs[0]
            && src0[62:52] != DBL_EXP_ONES |=> resW[31] == ($past(src0[63]) ^ $past(srcNeg[0]));
    endproperty
    a_split_sign: assert property (p_split_sign) else $error("slot zero modifier lost"); // RL7
    property p_bar_release;
        @(posedge mclk) disable iff (srst)
        threadRelease != '0 |-> threadRelease == $past(groupMask) && barArr_reg == '0;
    endproperty
    a_bar_release: assert property (p_bar_release) else $error("barrier release wrong"); // RL8
    property p_seq_single;
        @(posedge mclk) disable iff (srst)
        $onehot0(seqGrant) && ((seqGrant != '0) == (seqState_reg == SAM_SEQ_RUN));
    endproperty
    a_seq_single: assert property (p_seq_single) else $error("section grant not single"); // RL10
    property p_seq_pass;
        @(posedge mclk) disable iff (srst)
        seqState_reg == SAM_SEQ_RUN && issueValid && opSelect == OP_SEQ_CLOSE
            && (seqGrant & thrBit) != '0 |=> seqGrant != $past(seqGrant);
    endproperty
    a_seq_pass: assert property (p_seq_pass) else $error("section not passed on"); // RL11
    property p_i2f_one;
        @(posedge mclk) disable iff (srst)
        issueValid && opSelect == OP_INT_TO_SINGLE && src0[31:0] == 32'hffffffff
            |=> resValid && resX == 32'hbf800000;
    endproperty
    a_i2f_one: assert property (p_i2f_one) else $error("int to single wrong"); // RL13
endmodule : sam_alu_misc
`default_nettype wire

// ---- sam_alu_misc_tb.sv ----
// self-checking testbench for the shader alu misc-op unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin nMismatch++; \
    $display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module sam_alu_misc_tb;
    import sam_pkg::*;
    logic mclk, srst, issueValid, ldsWrEn, resValid, issueErr;
    logic [7:0] opSelect, groupMask, threadRelease, seqGrant;
    logic [2:0] issueThread;
    logic [3:0] issueSlots, srcNeg, srcAbs, modSlots, modNeg, modAbs;
    logic [63:0] src0;
    logic [31:0] parV0X, parV0Y, parD1X, parD1Y, parD2X, parD2Y, baryI, baryJ;
    logic [31:0] resX, resY, resZ, resW, seed;
    logic [1:0] ldsWrVertex;
    logic [5:0] ldsWrParam;
    logic [127:0] ldsWrData;
    logic [63:0] tv;
    logic [127:0] td;
    int nMismatch, totalChecks;
    sam_alu_misc uut (.mclk(mclk), .srst(srst), .issueValid(issueValid),
        .opSelect(opSelect), .issueThread(issueThread), .issueSlots(issueSlots),
        .srcNeg(srcNeg), .srcAbs(srcAbs), .src0(src0), .groupMask(groupMask),
        .parV0X(parV0X), .parV0Y(parV0Y), .parD1X(parD1X), .parD1Y(parD1Y),
        .parD2X(parD2X), .parD2Y(parD2Y), .baryI(baryI), .baryJ(baryJ),
        .ldsWrEn(ldsWrEn), .ldsWrVertex(ldsWrVertex), .ldsWrParam(ldsWrParam),
        .ldsWrData(ldsWrData), .resValid(resValid), .resX(resX), .resY(resY),
        .resZ(resZ), .resW(resW), .issueErr(issueErr),
        .threadRelease(threadRelease), .seqGrant(seqGrant));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // {fraction, exponent}; only slot 0 modifiers count
    function automatic logic [127:0] splitExp(input logic [63:0] v, input logic n,
                                              input logic a);
        logic s;
        logic [63:0] ex, fr;
        s = (v[63] & ~a) ^ n;
        if (v[62:52] == DBL_EXP_ONES) begin
            ex = {32'h0, SPLIT_EXP_SPECIAL};
            fr = (v[51:0] == 52'h0) ? QUIET_DOUBLE_NAN : {s, v[62:0]};
        end else if (v[62:52] == 11'h0) begin
            ex = 64'h0;
            fr = {s, 63'h0};
        end else begin
            ex = {53'h0, v[62:52]} - 64'd1022;
            fr = {s, FRAC_BIASED_EXP, v[51:0]};
        end
        return {fr, ex};
    endfunction : splitExp
    // signed integer to single, nearest even
    function automatic logic [31:0] i2f(input logic [31:0] v);
        logic [31:0] m, rem, half;
        logic [32:0] k;
        int p;
        if (v == 32'h0) return 32'h0;
        m = v[31] ? -v : v;
        p = 31;
        while (!m[p]) p--;
        if (p <= 23) begin
            k = 33'(m) << (23 - p);
        end else begin
            k = 33'(m >> (p - 23));
            rem = m & ((32'h1 << (p - 23)) - 32'h1);
            half = 32'h1 << (p - 24);
            if (rem > half || (rem == half && k[0])) k++;
            if (k[24]) begin
                k = k >> 1;
                p++;
            end
        end
        return {v[31], 8'(p + 127), k[22:0]};
    endfunction : i2f
    task automatic conclude();
        $display("checks %0d mismatches %0d", totalChecks, nMismatch);
        if (nMismatch == 0 && totalChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic issue(input logic [7:0] op, input logic [63:0] s, input int thr);
        @(posedge mclk);
        issueValid <= 1'b1;
        opSelect <= op;
        src0 <= s;
        issueThread <= 3'(thr);
        issueSlots <= modSlots;
        srcNeg <= modNeg;
        srcAbs <= modAbs;
        @(posedge mclk);
        issueValid <= 1'b0;
        #1;
    endtask : issue
    task automatic chkRes(input logic v, input logic err, input logic [127:0] r);
        `CHK(resValid, v)
        `CHK(issueErr, err)
        `CHK({resW, resZ, resY, resX}, r)
    endtask : chkRes
    task automatic ldsWrite(input logic [1:0] vx, input logic [5:0] p, input logic [127:0] d);
        @(posedge mclk);
        ldsWrEn <= 1'b1;
        ldsWrVertex <= vx;
        ldsWrParam <= p;
        ldsWrData <= d;
        @(posedge mclk);
        ldsWrEn <= 1'b0;
    endtask : ldsWrite
    task automatic doSplit(input logic [63:0] v);
        logic [127:0] e;
        modNeg = 4'(xs());
        modAbs = 4'(xs());
        e = splitExp(v, modNeg[0], modAbs[0]);
        issue(OP_SPLIT_DOUBLE, v, 0);
        chkRes(1'b1, 1'b0, e);
    endtask : doSplit
    task automatic barrierRun(input logic [7:0] m);
        int last;
        last = 0;
        for (int i = 0; i < 8; i++) if (m[i]) last = i;
        @(posedge mclk);
        groupMask <= m;
        if (m != 8'hff) begin
            for (int i = 7; i >= 0; i--) if (!m[i]) last = last + 0 * i;
            issue(OP_BARRIER, 64'h0, $clog2(int'(~m & -(~m))));
            `CHK(threadRelease, 8'h00)
        end
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                issue(OP_BARRIER, 64'h0, i);
                `CHK(threadRelease, (i == last) ? m : 8'h00)
                if (i != last) begin
                    issue(OP_BARRIER, 64'h0, i);
                    `CHK(threadRelease, 8'h00)
                end
            end
        end
        @(posedge mclk);
        #1;
        `CHK(threadRelease, 8'h00)
    endtask : barrierRun
    task automatic seqRun(input logic [7:0] m);
        logic [7:0] cur, rest;
        int last;
        last = 0;
        for (int i = 0; i < 8; i++) if (m[i]) last = i;
        cur = m & -m;
        @(posedge mclk);
        groupMask <= m;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                issue(OP_SEQ_OPEN, 64'h0, i);
                `CHK(seqGrant, (i == last) ? cur : 8'h00)
            end
        end
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                issue(OP_SEQ_CLOSE, 64'h0, (i + 1) % 8);
                `CHK(seqGrant, cur)
                issue(OP_SEQ_CLOSE, 64'h0, i);
                rest = m & (8'hff << (i + 1));
                cur = rest & -rest;
                `CHK(seqGrant, cur)
            end
        end
    endtask : seqRun
    initial begin
        seed = 32'hf676956e;
        {srst, issueValid, ldsWrEn} = 3'b100;
        {opSelect, issueThread, src0, groupMask} = '0;
        {issueSlots, modSlots} = {4'hf, 4'hf};
        {srcNeg, srcAbs, modNeg, modAbs} = '0;
        {parV0X, parV0Y, parD1X, parD1Y, parD2X, parD2Y, baryI, baryJ} = '0;
        {ldsWrVertex, ldsWrParam, ldsWrData} = '0;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        #1;
        chkRes(1'b0, 1'b0, 128'h0);
        `CHK({threadRelease, seqGrant}, 16'h0)
        issue(OP_SPLIT_DOUBLE, 64'h4008000000000000, 0);
        chkRes(1'b1, 1'b0, {64'h3fe8000000000000, 64'h2});
        doSplit(64'h7ff0000000000000);
        doSplit(64'hfff0000000000000);
        doSplit(64'h7ff8000000000001);
        doSplit(64'h8000000000000000);
        doSplit(64'h000f000000000000);
        doSplit(64'h0010000000000000);
        doSplit(64'hc010000000000001);
        for (int i = 0; i < 30; i++) begin
            tv = {xs(), xs()};
            if (i % 4 == 0) tv[62:52] = DBL_EXP_ONES;
            if (i % 4 == 1) tv[62:52] = 11'h0;
            doSplit(tv);
        end
        {modNeg, modAbs, modSlots} = {4'h0, 4'h0, 4'h7};
        issue(OP_SPLIT_DOUBLE, 64'h4008000000000000, 0);
        chkRes(1'b0, 1'b1, 128'h0);
        modSlots = 4'hf;
        issue(8'h00, 64'h1, 0);
        chkRes(1'b0, 1'b0, 128'h0);
        for (int i = 0; i < 36; i++) begin
            tv[31:0] = (i < 6) ? 32'(i * 32'h3fffff01) : xs();
            if (i == 0) tv[31:0] = 32'h80000000;
            if (i == 1) tv[31:0] = 32'h01000001;
            if (i == 2) tv[31:0] = 32'h01000003;
            if (i == 3) tv[31:0] = 32'hffffffff;
            issue(OP_INT_TO_SINGLE, {32'h0, tv[31:0]}, 0);
            chkRes(1'b1, 1'b0, {96'h0, i2f(tv[31:0])});
        end
        ldsWrite(2'd0, 6'd32, {32'h40800000, 32'h40400000, 32'h40000000, 32'h3f800000});
        ldsWrite(2'd1, 6'd32, {32'h41000000, 32'h40c00000, 32'h40400000, 32'h40000000});
        ldsWrite(2'd2, 6'd32, {32'h40a00000, 32'h40800000, 32'h40800000, 32'h40400000});
        issue(OP_LOAD_V0, 64'd32, 0);
        chkRes(1'b1, 1'b0, {32'h40800000, 32'h40400000, 32'h40000000, 32'h3f800000});
        issue(OP_LOAD_D1, 64'd32, 0);
        chkRes(1'b1, 1'b0, {32'h40800000, 32'h40400000, 32'h3f800000, 32'h3f800000});
        issue(OP_LOAD_D2, 64'd32, 0);
        chkRes(1'b1, 1'b0, {32'h3f800000, 32'h3f800000, 32'h40000000, 32'h40000000});
        issue(OP_LOAD_V0, 64'd33, 0);
        chkRes(1'b0, 1'b1, 128'h0);
        for (int i = 0; i < 8; i++) begin
            tv = 64'(xs() % 33);
            td = {xs(), xs(), xs(), xs()};
            ldsWrite(2'd0, tv[5:0], td);
            issue(OP_LOAD_V0, tv, 0);
            chkRes(1'b1, 1'b0, td);
        end
        @(posedge mclk);
        {parV0X, parD1X, parD2X} <= {32'h3f800000, 32'h40000000, 32'h40800000};
        {parV0Y, parD1Y, parD2Y} <= {32'h40000000, 32'h40800000, 32'h41000000};
        {baryI, baryJ} <= {32'h3f000000, 32'h3e800000};
        issue(OP_INTERP_FIRST_CHANNEL, 64'h0, 0);
        chkRes(1'b1, 1'b0, {96'h0, 32'h40400000});
        issue(OP_INTERP_FIRST_TWO_CHANNELS, 64'h0, 0);
        chkRes(1'b1, 1'b0, {64'h0, 32'h40c00000, 32'h40400000});
        barrierRun(8'h03);
        barrierRun(8'hff);
        barrierRun(8'h80);
        for (int i = 0; i < 4; i++) barrierRun(8'(xs()) | 8'h10);
        seqRun(8'h25);
        seqRun(8'h01);
        for (int i = 0; i < 3; i++) seqRun(8'(xs()) | 8'h02);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge mclk);
        nMismatch++;
        conclude();
    end
endmodule : sam_alu_misc_tb
`default_nettype wire
